// ===== psf_params.svh
`ifndef PSF_PARAMS_SVH
`define PSF_PARAMS_SVH
`define PSF_RESET_VAL 8'h80
`define PSF_BIT_ZERO 7
`define PSF_BIT_SIGN 6
`define PSF_BIT_RSVD 5
`define PSF_BIT_UF_HI 4
`define PSF_BIT_UF_LO 3
`define PSF_BIT_OV 2
`define PSF_BIT_CARRY 1
`define PSF_BIT_EQ 0
`define PSF_ACC_W 16
`define PSF_ACC_N 16
`define PSF_ADDR_FLAGS 32'h0000_0000
`define PSF_ADDR_ACC_SEL 32'h0000_0004
`define PSF_ADDR_ACC_VAL 32'h0000_0008
`endif

// ===== psf_pkg.sv
package psf_pkg;
	typedef enum logic [2:0] {
		PSF_OP_NONE = 3'h0,
		PSF_OP_ADD = 3'h1,
		PSF_OP_ADD_WITH_CARRY_OP = 3'h2,
		PSF_OP_SUB = 3'h3,
		PSF_OP_SUBTRACT_WITH_BORROW_OP = 3'h4,
		PSF_OP_CMP = 3'h5
	} psf_op_t;
endpackage : psf_pkg

// ===== psf_arith.sv
`timescale 1ns/100ps
`include "psf_params.svh"
// ****************************************
// add/subtract unit with carry chain taps
// ****************************************
module psf_arith
	import psf_pkg::*;
(
	// operation
	input wire psf_op_t op_in,
	input wire logic [15:0] a_in,
	input wire logic [15:0] b_in,
	input wire logic carry_in,
	// result
	output logic [15:0] res_out,
	output logic carry_out,
	output logic ovf_out,
	output logic equal_out
);
	logic [15:0] b_eff;
	logic cin_eff;
	logic [15:0] low_sum;
	logic c14;
	logic c15;
	// subtract as a plus inverted b plus 1, borrow is inverted carry
	always_comb begin
		b_eff = b_in;
		cin_eff = 1'b0;
		unique case (op_in)
			PSF_OP_ADD_WITH_CARRY_OP: cin_eff = carry_in;
			PSF_OP_SUB, PSF_OP_CMP: begin
				b_eff = ~b_in;
				cin_eff = 1'b1;
			end
			PSF_OP_SUBTRACT_WITH_BORROW_OP: begin
				b_eff = ~b_in;
				cin_eff = ~carry_in;
			end
			default: cin_eff = 1'b0;
		endcase
	end
	// carry out of bit 14 and of bit 15
	assign {c14, low_sum[14:0]} = {1'b0, a_in[14:0]} + {1'b0, b_eff[14:0]} + {15'h0000, cin_eff};
	assign {c15, low_sum[15]} = {1'b0, a_in[15]} + {1'b0, b_eff[15]} + {1'b0, c14};
	assign res_out = low_sum;
	assign ovf_out = c14 ^ c15;
	// borrow for SUB and subtract with borrow is the absent carry; CMP passes the plain carry
	assign carry_out = (op_in == PSF_OP_SUB || op_in == PSF_OP_SUBTRACT_WITH_BORROW_OP) ? ~c15 : c15;
	assign equal_out = (a_in == b_in);
endmodule : psf_arith

// ===== psf_flags.sv
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "psf_params.svh"
// ****************************************
// status flag register with accumulator file
// ****************************************
module psf_flags
	import psf_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	// wishbone slave
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [31:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// execution
	input wire psf_op_t OP_IN,
	input wire logic [15:0] OPERAND_IN,
	// state
	output logic [7:0] STATUS_FLAGS_OUT,
	output logic [15:0] ACC_OUT
);
	logic [15:0] acc_q [`PSF_ACC_N];
	logic [3:0] accumulator_pointer_q;
	logic [1:0] user_flags_q;
	logic overflow_flag_q;
	logic carry_q;
	logic equal_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic [15:0] acc_sel;
	logic [15:0] res;
	logic res_c;
	logic res_v;
	logic res_eq;
	logic wr_en;
	logic rd_en;
	logic arith_op;
	logic [7:0] flags;

	// ****************************************
	// datapath
	// ****************************************
	assign acc_sel = acc_q[accumulator_pointer_q];
	assign arith_op = (OP_IN != PSF_OP_NONE) && (OP_IN != PSF_OP_CMP);
	assign wr_en = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !ack_q;
	assign rd_en = WB_CYC_IN && WB_STB_IN && !WB_WE_IN && !ack_q;

	psf_arith u_arith (
		.op_in(OP_IN),
		.a_in(acc_sel),
		.b_in(OPERAND_IN),
		.carry_in(carry_q),
		.res_out(res),
		.carry_out(res_c),
		.ovf_out(res_v),
		.equal_out(res_eq)
	);

	// assembled flag byte
	always_comb begin
		flags = 8'h00;
		flags[`PSF_BIT_ZERO] = (acc_sel == 16'h0000);
		flags[`PSF_BIT_SIGN] = acc_sel[`PSF_ACC_W-1];
		flags[`PSF_BIT_RSVD] = 1'b0;
		flags[`PSF_BIT_UF_HI:`PSF_BIT_UF_LO] = user_flags_q;
		flags[`PSF_BIT_OV] = overflow_flag_q;
		flags[`PSF_BIT_CARRY] = carry_q;
		flags[`PSF_BIT_EQ] = equal_q;
	end

	// ****************************************
	// accumulator file, result written with flags
	// ****************************************
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			for (int i = 0; i < `PSF_ACC_N; i++) begin
				acc_q[i] <= 16'h0000;
			end
		end else if (arith_op) begin
			acc_q[accumulator_pointer_q] <= res;
		end else if (wr_en && WB_ADR_IN == `PSF_ADDR_ACC_VAL) begin
			if (WB_SEL_IN[0]) acc_q[accumulator_pointer_q][7:0] <= WB_DAT_IN[7:0];
			if (WB_SEL_IN[1]) acc_q[accumulator_pointer_q][15:8] <= WB_DAT_IN[15:8];
		end
	end

	// pointer written by software
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			accumulator_pointer_q <= 4'h0;
		end else if (wr_en && WB_ADR_IN == `PSF_ADDR_ACC_SEL && WB_SEL_IN[0]) begin
			accumulator_pointer_q <= WB_DAT_IN[3:0];
		end
	end

	// ****************************************
	// flag bits
	// ****************************************
	// user flags: software only
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			user_flags_q <= 2'h0;
		end else if (wr_en && WB_ADR_IN == `PSF_ADDR_FLAGS && WB_SEL_IN[0]) begin
			user_flags_q <= WB_DAT_IN[`PSF_BIT_UF_HI:`PSF_BIT_UF_LO];
		end
	end

	// overflow: hardware only, software writes ignored
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			overflow_flag_q <= 1'b0;
		end else if (arith_op) begin
			overflow_flag_q <= res_v;
		end
	end

	// carry: hardware update wins over a same-cycle software write
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			carry_q <= 1'b0;
		end else if (arith_op) begin
			carry_q <= res_c;
		end else if (wr_en && WB_ADR_IN == `PSF_ADDR_FLAGS && WB_SEL_IN[0]) begin
			carry_q <= WB_DAT_IN[`PSF_BIT_CARRY];
		end
	end

	// equal: compare result wins over software write
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			equal_q <= 1'b0;
		end else if (OP_IN == PSF_OP_CMP) begin
			equal_q <= res_eq;
		end else if (wr_en && WB_ADR_IN == `PSF_ADDR_FLAGS && WB_SEL_IN[0]) begin
			equal_q <= WB_DAT_IN[`PSF_BIT_EQ];
		end
	end

	// ****************************************
	// wishbone answer, one wait state
	// ****************************************
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= WB_CYC_IN && WB_STB_IN && !ack_q;
		end
	end

	// read data, unmapped reads zero
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			rdat_q <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (WB_ADR_IN)
				`PSF_ADDR_FLAGS: rdat_q <= {24'h000000, flags};
				`PSF_ADDR_ACC_SEL: rdat_q <= {28'h0000000, accumulator_pointer_q};
				`PSF_ADDR_ACC_VAL: rdat_q <= {16'h0000, acc_sel};
				default: rdat_q <= 32'h0000_0000;
			endcase
		end
	end

	assign WB_ACK_OUT = ack_q;
	assign WB_DAT_OUT = rdat_q;
	assign STATUS_FLAGS_OUT = flags;
	assign ACC_OUT = acc_sel;

	// ****************************************
	// checks
	// ****************************************
	sequence s_add_op;
		arith_op ##0 (res_v == 1'b1);
	endsequence
	chk_reset_value: assert property (@(posedge SYS_CLK_IN) $past(RST_IN) |-> STATUS_FLAGS_OUT == `PSF_RESET_VAL) else $error("reset flag value wrong");
	chk_zero_flag: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) STATUS_FLAGS_OUT[7] == (ACC_OUT == 16'h0000)) else $error("zero flag mismatch");
	chk_sign_flag: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) STATUS_FLAGS_OUT[6] == ACC_OUT[15]) else $error("sign flag mismatch");
	chk_rsvd_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) !STATUS_FLAGS_OUT[5]) else $error("reserved bit set");
	chk_ov_set: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) s_add_op |=> STATUS_FLAGS_OUT[2]) else $error("overflow not set");
	chk_ov_sign: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) (OP_IN == PSF_OP_ADD && !acc_sel[15] && !OPERAND_IN[15] && res[15]) |=> STATUS_FLAGS_OUT[2]) else $error("wrong sign not flagged");
	chk_ov_ro: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) !arith_op |=> $stable(STATUS_FLAGS_OUT[2])) else $error("overflow changed without op");
	chk_user_only: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) !(wr_en && WB_ADR_IN == `PSF_ADDR_FLAGS) |=> $stable(STATUS_FLAGS_OUT[4:3])) else $error("user flags changed");
	chk_carry_op: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) arith_op |=> STATUS_FLAGS_OUT[1] == $past(res_c)) else $error("carry wrong");
	chk_equal_cmp: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) (OP_IN == PSF_OP_CMP) |=> STATUS_FLAGS_OUT[0] == (($past(acc_sel)) == $past(OPERAND_IN))) else $error("equal flag wrong");
endmodule : psf_flags

// ===== processor_status_flags_bench.sv
`timescale 1ns/100ps
module processor_status_flags_bench
	import psf_pkg::*;
;
	// clock, reset and stimulus
	logic clk, rst, cyc, stb, we, ack;
	logic [31:0] adr, wdat, rdat, rd;
	logic [3:0] sel;
	psf_op_t op;
	logic [15:0] opd, acc;
	logic [7:0] flags;
	int errors, n_tests, cycles;
	// ****************************************
	// design under test
	// ****************************************
	psf_flags dut (.SYS_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
		.WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .OP_IN(op), .OPERAND_IN(opd),
		.STATUS_FLAGS_OUT(flags), .ACC_OUT(acc));
	// free running clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			tally_and_finish();
		end
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// one classic cycle, waits for ack, then one idle cycle
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do @(posedge clk); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask : wb
	// one operation cycle, flags looked at once it lands
	task automatic ex(input psf_op_t o, input logic [15:0] b);
		@(posedge clk);
		op <= o;
		opd <= b;
		@(posedge clk);
		op <= PSF_OP_NONE;
		#1;
	endtask : ex
	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
	endtask : do_reset
	task automatic tally_and_finish();
		if (errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_software_access();
		chk(flags, 32'h80);
		wb(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h80);
		wb(1'b1, 32'h0, 32'hFF);
		wb(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h9B);
		wb(1'b1, 32'h20, 32'hFF);
		wb(1'b0, 32'h20, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, 32'h8, 32'h7FFF);
		chk(flags, 32'h1B);
	endtask : t_software_access
	task automatic t_arith();
		ex(PSF_OP_ADD, 16'h0001);
		chk({acc, flags}, 32'h8000_5D);
		ex(PSF_OP_ADD, 16'h8000);
		chk({acc, flags}, 32'h0000_9F);
		wb(1'b1, 32'h0, 32'h00);
		chk(flags, 32'h84);
		ex(PSF_OP_SUB, 16'h0001);
		chk({acc, flags}, 32'hFFFF_42);
		ex(PSF_OP_CMP, 16'h0000);
		chk(flags, 32'h42);
		ex(PSF_OP_CMP, 16'hFFFF);
		chk({acc, flags}, 32'hFFFF_43);
		ex(PSF_OP_ADD_WITH_CARRY_OP, 16'h0000);
		chk({acc, flags}, 32'h0000_83);
		ex(PSF_OP_SUBTRACT_WITH_BORROW_OP, 16'h0000);
		chk({acc, flags}, 32'hFFFF_43);
		ex(PSF_OP_ADD, 16'h0001);
		chk({acc, flags}, 32'h0000_83);
	endtask : t_arith
	task automatic t_pointer();
		wb(1'b1, 32'h8, 32'h8001);
		wb(1'b1, 32'h4, 32'hF);
		chk({acc, flags}, 32'h0000_83);
		wb(1'b0, 32'h4, 32'h0);
		chk(rd, 32'hF);
		wb(1'b1, 32'h4, 32'h0);
		chk({acc, flags}, 32'h8001_43);
		do_reset();
		chk({acc, flags}, 32'h0000_80);
	endtask : t_pointer
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		errors = 0;
		n_tests = 0;
		cycles = 0;
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 32'h0;
		wdat = 32'h0;
		sel = 4'h0;
		op = PSF_OP_NONE;
		opd = 16'h0;
		do_reset();
		t_software_access();
		t_arith();
		t_pointer();
		tally_and_finish();
	end
endmodule : processor_status_flags_bench
